// >>> design/flash_status_byte_one.sv
// Operation
// - Lock set: sector protect and unprotect commands ignored, registers unchanged.
// - Lock set: global protect and unprotect not carried out.
// - Lock clear: all four protection requests processed normally.
// - Lock returns to zero on reset.
// - Pin deasserted: lock writes freely; pin asserted: only zero to one.
// - Status write stores only bit 7; bits 5:2 request a global protect or unprotect.
// - Sequential flag shows program mode, byte/page after reset.
// - Fail flag set when a byte failed in the last erase or program.
// - Fail flag not set on an aborted erase or program.
// - Fail flag refreshed at the end of each erase and program that is not aborted.
// - Pin flag shows the write-protect pin level.
// - Two-bit summary reports none, some or all sectors protected.
// - Summary 00 none, 01 some, 11 all (default), 10 reserved.
// - Write latch flag 0 not enabled (default), 1 enabled.
// - Busy flag 0 ready, 1 internal operation in progress.
// - Write latch clears after disable, status write, protect, program, erase, reset.
`timescale 1ns/1ps
module flash_status_byte_one (
	// Clock and reset
	input  wire logic                                  CLK_SYS,
	input  wire logic                                  RST_N,
	// Write-protect pin, active low
	input  wire logic                                  WP_N,
	// Decoded commands from the serial front end, one-cycle pulses
	input  wire logic                                  WR_ENABLE,
	input  wire logic                                  WR_DISABLE,
	input  wire logic                                  STATUS_WRITE,
	input  wire logic [7:0]                            STATUS_DATA,
	input  wire logic                                  SECTOR_PROTECT,
	input  wire logic                                  SECTOR_UNPROTECT,
	input  wire logic [flash_status_pkg::SECTOR_W-1:0] SECTOR_SEL,
	// Program and erase engine
	input  wire logic                                  ENGINE_BUSY,
	input  wire logic                                  SEQ_MODE,
	input  wire logic                                  OP_DONE,
	input  wire logic                                  OP_FAIL,
	input  wire logic                                  OP_ABORT,
	// Status readout
	input  wire logic                                  READ_LOAD,
	input  wire logic                                  READ_SHIFT,
	output logic                                       READ_BIT,
	output logic      [7:0]                            STATUS_BYTE,
	// Protection state for the array
	output logic      [flash_status_pkg::NUM_SECTORS-1:0] SECTOR_PROTECTED
);
	// ----------------------------------------
	// Flags
	// ----------------------------------------
	logic       protection_lock;
	logic       seq_program_flag;
	logic       program_fail_flag;
	logic       protect_pin_level;
	logic       write_latch;
	logic       busy_flag;
	logic [1:0] sw_protect_summary;
	logic [flash_status_pkg::NUM_SECTORS-1:0] protect_bits;
	logic [7:0] shift_reg;
	logic [2:0] shift_cnt;

	logic       accept_status;
	logic       accept_sector;
	logic [3:0] global_field;
	logic       next_lock;

	// A status write is only honoured with the latch set and the engine idle.
	assign accept_status = STATUS_WRITE && write_latch && !busy_flag;
	assign accept_sector = write_latch && !busy_flag && !protection_lock;
	assign global_field  = STATUS_DATA[flash_status_pkg::GLOBAL_HI:flash_status_pkg::GLOBAL_LO];

	// ----------------------------------------
	// Protection lock
	// ----------------------------------------
	// The pin only guards the one-to-zero direction. Setting the lock is always
	// allowed, so a host can freeze the sectors even with the pin held low.
	always_comb begin
		next_lock = STATUS_DATA[flash_status_pkg::LOCK_BIT];
		if (!WP_N && protection_lock && !next_lock) begin
			next_lock = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			protection_lock <= flash_status_pkg::LOCK_RESET;
		end else if (accept_status) begin
			protection_lock <= next_lock;
		end
	end

	// ----------------------------------------
	// Global field decoding
	// ----------------------------------------
	// Only the all-ones and all-zeros patterns act. Every other pattern leaves the
	// sectors alone, so a byte that moves the lock with another pattern never touches them.
	function automatic logic field_is(input logic [3:0] field, input logic [3:0] pattern);
		field_is = (field == pattern);
	endfunction : field_is

	// ----------------------------------------
	// Sector protection store
	// ----------------------------------------
	// The prior lock value gates the global operation, so a write that sets the
	// lock and asks for a global change in the same byte still performs it.
	sector_protect_store u_store (
		.clk     (CLK_SYS),
		.rst_n   (RST_N),
		.set_one (SECTOR_PROTECT && accept_sector),
		.clr_one (SECTOR_UNPROTECT && accept_sector),
		.sector  (SECTOR_SEL),
		.set_all (accept_status && !protection_lock && field_is(global_field, flash_status_pkg::GLOBAL_PROTECT)),
		.clr_all (accept_status && !protection_lock && field_is(global_field, flash_status_pkg::GLOBAL_UNPROTECT)),
		.protect (protect_bits),
		.summary (sw_protect_summary)
	);

	// ----------------------------------------
	// Write enable latch
	// ----------------------------------------
	// With the engine idle, write enable wins over every clear in the same cycle. A status write refused
	// because the engine is busy still clears the latch, as the whole command was
	// received; the host has to enable again once the engine is idle.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			write_latch <= 1'b0;
		end else if (WR_ENABLE && !busy_flag) begin
			write_latch <= 1'b1;
		end else if (WR_DISABLE || (STATUS_WRITE && write_latch) || OP_DONE || OP_ABORT
				|| ((SECTOR_PROTECT || SECTOR_UNPROTECT) && write_latch)) begin
			write_latch <= 1'b0;
		end
	end

	// ----------------------------------------
	// Engine flags
	// ----------------------------------------
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			program_fail_flag <= 1'b0;
		end else if (OP_DONE && !OP_ABORT) begin
			program_fail_flag <= OP_FAIL;
		end
	end

	// The busy flag trails the engine by one clock. The write gates use this
	// registered copy, so every decision in a cycle sees one consistent value.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			seq_program_flag  <= 1'b0;
			busy_flag         <= 1'b0;
			protect_pin_level <= 1'b0;
		end else begin
			seq_program_flag  <= SEQ_MODE;
			busy_flag         <= ENGINE_BUSY;
			protect_pin_level <= WP_N;
		end
	end

	// ----------------------------------------
	// Readout
	// ----------------------------------------
	logic [7:0] status_now;

	// The parallel copy lags the flags by one clock; the serial path loads from
	// the live flags instead, so a poll never sees a byte older than its request.
	// fixed layout
	always_comb begin
		status_now = 8'h00;
		status_now[flash_status_pkg::LOCK_BIT]  = protection_lock;
		status_now[flash_status_pkg::SEQ_BIT]   = seq_program_flag;
		status_now[flash_status_pkg::FAIL_BIT]  = program_fail_flag;
		status_now[flash_status_pkg::PIN_BIT]   = protect_pin_level;
		status_now[flash_status_pkg::SUMMARY_HI:flash_status_pkg::SUMMARY_LO] = sw_protect_summary;
		status_now[flash_status_pkg::LATCH_BIT] = write_latch;
		status_now[flash_status_pkg::BUSY_BIT]  = busy_flag;
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			STATUS_BYTE      <= flash_status_pkg::STATUS_RESET;
			SECTOR_PROTECTED <= {flash_status_pkg::NUM_SECTORS{flash_status_pkg::SECTOR_RESET}};
		end else begin
			STATUS_BYTE      <= status_now;
			SECTOR_PROTECTED <= protect_bits;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			shift_reg <= 8'h00;
			shift_cnt <= 3'h0;
			READ_BIT  <= 1'b0;
		end else if (READ_LOAD) begin
			// Reloading each byte lets a poll loop watch the busy flag fall.
			shift_reg <= {status_now[6:0], 1'b0};
			shift_cnt <= 3'h0;
			READ_BIT  <= status_now[7];
		end else if (READ_SHIFT) begin
			if (shift_cnt == flash_status_pkg::BIT_LAST) begin
				// After bit 0 the next shift starts a fresh byte, so a held read keeps polling.
				shift_reg <= {status_now[6:0], 1'b0};
				shift_cnt <= 3'h0;
				READ_BIT  <= status_now[7];
			end else begin
				shift_reg <= {shift_reg[6:0], 1'b0};
				shift_cnt <= shift_cnt + 3'h1;
				READ_BIT  <= shift_reg[7];
			end
		end
	end
endmodule : flash_status_byte_one

// >>> design/flash_status_pkg.sv
package flash_status_pkg;
	// Bit layout of status byte one, bit 7 first on the serial line.
	localparam int LOCK_BIT     = 7;
	localparam int SEQ_BIT      = 6;
	localparam int FAIL_BIT     = 5;
	localparam int PIN_BIT      = 4;
	localparam int SUMMARY_HI   = 3;
	localparam int SUMMARY_LO   = 2;
	localparam int LATCH_BIT    = 1;
	localparam int BUSY_BIT     = 0;
	// Global protect field of the status write byte.
	localparam int GLOBAL_HI    = 5;
	localparam int GLOBAL_LO    = 2;
	localparam logic [3:0] GLOBAL_PROTECT   = 4'hF;
	localparam logic [3:0] GLOBAL_UNPROTECT = 4'h0;
	// Protection summary encodings.
	localparam logic [1:0] SUMMARY_NONE = 2'h0;
	localparam logic [1:0] SUMMARY_SOME = 2'h1;
	localparam logic [1:0] SUMMARY_ALL  = 2'h3;
	// Sector count and reset values.
	localparam int NUM_SECTORS  = 4;
	localparam int SECTOR_W     = 2;
	localparam logic [7:0] STATUS_RESET = 8'h0C;
	localparam logic       LOCK_RESET   = 1'b0;
	localparam logic       SECTOR_RESET = 1'b1;
	localparam logic [2:0] BIT_LAST     = 3'h7;
endpackage : flash_status_pkg

// >>> design/sector_protect_store.sv
`timescale 1ns/1ps
module sector_protect_store (
	// Clock and reset
	input  wire logic                                   clk,
	input  wire logic                                   rst_n,
	// Update requests, already qualified by the lock
	input  wire logic                                   set_one,
	input  wire logic                                   clr_one,
	input  wire logic [flash_status_pkg::SECTOR_W-1:0]  sector,
	input  wire logic                                   set_all,
	input  wire logic                                   clr_all,
	// State
	output logic      [flash_status_pkg::NUM_SECTORS-1:0] protect,
	output logic      [1:0]                             summary
);
	genvar g;
	generate
		for (g = 0; g < flash_status_pkg::NUM_SECTORS; g++) begin : g_sec
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					protect[g] <= flash_status_pkg::SECTOR_RESET;
				end else if (set_all || (set_one && int'(sector) == g)) begin
					protect[g] <= 1'b1;
				end else if (clr_all || (clr_one && int'(sector) == g)) begin
					protect[g] <= 1'b0;
				end
			end
		end
	endgenerate

	always_comb begin
		if (&protect) begin
			summary = flash_status_pkg::SUMMARY_ALL;
		end else if (|protect) begin
			summary = flash_status_pkg::SUMMARY_SOME;
		end else begin
			summary = flash_status_pkg::SUMMARY_NONE;
		end
	end
endmodule : sector_protect_store

// >>> tb/flash_host.sv
`timescale 1ns/1ps
module flash_host (
	// Clock and serial read bit
	input  wire logic       clk,
	input  wire logic       rb,
	// Command pulses, data byte and sector number
	output logic      [8:0] p,
	output logic      [7:0] dat,
	output logic      [1:0] sel
);
	initial begin
		p = 9'h000;
		dat = 8'h00;
		sel = 2'h0;
	end
	// Data is inverted once the pulse ends so nothing relies on a stale byte.
	task automatic pulse(input int i, input logic [7:0] d, input logic [1:0] s);
		@(posedge clk);
		#1 p[i] = 1'b1;
		dat = d;
		sel = s;
		@(posedge clk);
		#1 p[i] = 1'b0;
		dat = ~d;
	endtask : pulse
	task automatic rd(output logic [7:0] b);
		pulse(7, 8'h00, 2'h0);
		b[7] = rb;
		for (int n = 6; n >= 0; n--) begin
			pulse(8, 8'h00, 2'h0);
			b[n] = rb;
		end
	endtask : rd
endmodule : flash_host

// >>> tb/flash_status_assertions.sv
`timescale 1ns/1ps
module flash_status_checker (
	input wire logic       CLK_SYS,
	input wire logic       RST_N,
	input wire logic       WP_N,
	input wire logic       WR_ENABLE,
	input wire logic       WR_DISABLE,
	input wire logic       STATUS_WRITE,
	input wire logic       ENGINE_BUSY,
	input wire logic       OP_DONE,
	input wire logic       OP_FAIL,
	input wire logic       OP_ABORT,
	input wire logic [7:0] STATUS_BYTE,
	input wire logic [flash_status_pkg::NUM_SECTORS-1:0] SECTOR_PROTECTED
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	// Edges since release; history from inside reset is not trusted.
	logic [1:0] up;
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) up <= 2'h0;
		else if (up != 2'h3) up <= up + 2'h1;
	end
	// Pin level and busy flag are registered once and then copied into the byte.
	a_pin_flag: assert property (up[1] |-> STATUS_BYTE[4] == $past(WP_N, 2))
		else $error("pin flag does not follow the pin");
	a_busy_flag: assert property (up[1] |-> STATUS_BYTE[0] == $past(ENGINE_BUSY, 2))
		else $error("busy flag does not follow the engine");
	// Both outputs are copied from the same store at the same edge.
	a_summary_map: assert property (up != 2'h0 |-> STATUS_BYTE[3:2] == (&SECTOR_PROTECTED ? 2'h3
		: (|SECTOR_PROTECTED ? 2'h1 : 2'h0))) else $error("summary does not match sectors");
	a_lock_cause: assert property ($changed(STATUS_BYTE[7]) |-> $past(STATUS_WRITE, 2))
		else $error("lock changed without a status write");
	a_lock_pin: assert property ($fell(STATUS_BYTE[7]) |-> $past(WP_N, 2))
		else $error("lock cleared while pin asserted");
	// The lock as it stood before the write gates the store, so look one sample back.
	a_locked_store: assert property ($changed(SECTOR_PROTECTED) |-> !$past(STATUS_BYTE[7]))
		else $error("sectors changed while locked");
	a_fail_cause: assert property ($rose(STATUS_BYTE[5]) |-> $past(OP_DONE && OP_FAIL && !OP_ABORT, 2))
		else $error("fail flag set without a failed operation");
	a_fail_clear: assert property ($fell(STATUS_BYTE[5]) |-> $past(OP_DONE && !OP_FAIL, 2))
		else $error("fail flag cleared without a good operation");
	a_latch_drop: assert property (up == 2'h3 && $past(WR_DISABLE && !WR_ENABLE, 2) |-> !STATUS_BYTE[1])
		else $error("write latch not cleared");
endmodule : flash_status_checker
bind flash_status_byte_one flash_status_checker chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .WP_N(WP_N),
	.WR_ENABLE(WR_ENABLE), .WR_DISABLE(WR_DISABLE), .STATUS_WRITE(STATUS_WRITE), .ENGINE_BUSY(ENGINE_BUSY),
	.OP_DONE(OP_DONE), .OP_FAIL(OP_FAIL), .OP_ABORT(OP_ABORT), .STATUS_BYTE(STATUS_BYTE),
	.SECTOR_PROTECTED(SECTOR_PROTECTED));

// >>> tb/flash_status_byte_one_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module flash_status_byte_one_tb;
	logic       clk = 1'b0, rst_n = 1'b0, wp_n = 1'b1, busy = 1'b0, seq = 1'b0, rb;
	logic [8:0] p;
	logic [7:0] dat, sb, got;
	logic [1:0] sel;
	logic [3:0] prot;
	int         err_total = 0, samples_checked = 0;
	always #50 clk = ~clk;
	flash_host h (.clk(clk), .rb(rb), .p(p), .dat(dat), .sel(sel));
	flash_status_byte_one dut (.CLK_SYS(clk), .RST_N(rst_n), .WP_N(wp_n), .WR_ENABLE(p[0]), .WR_DISABLE(p[1]),
		.STATUS_WRITE(p[2]), .STATUS_DATA(dat), .SECTOR_PROTECT(p[3]), .SECTOR_UNPROTECT(p[4]), .SECTOR_SEL(sel),
		.ENGINE_BUSY(busy), .SEQ_MODE(seq), .OP_DONE(p[5]), .OP_FAIL(dat[0]), .OP_ABORT(p[6]),
		.READ_LOAD(p[7]), .READ_SHIFT(p[8]), .READ_BIT(rb), .STATUS_BYTE(sb), .SECTOR_PROTECTED(prot));
	// Three edges cover flag update, byte copy and the delayed busy flag.
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask : settle
	task automatic wr(input logic [7:0] d);
		h.pulse(0, 8'h00, 2'h0);
		h.pulse(2, d, 2'h0);
		settle;
	endtask : wr
	task automatic t_reset;
		// Outputs take their reset values at the first clock edge, not at time zero.
		repeat (5) @(posedge clk);
		#1;
		`CHK(sb, 8'h0C)
		`CHK(prot, 4'hF)
		rst_n = 1'b1;
		settle;
		`CHK(sb, 8'h1C)
		h.rd(got);
		`CHK(got, 8'h1C)
		$display("test reset done");
	endtask : t_reset
	task automatic t_lock;
		wp_n = 1'b0;
		wr(8'h84);
		`CHK(sb, 8'h8C)
		wr(8'h00);
		`CHK(sb[7], 1'b1)
		`CHK(prot, 4'hF)
		h.pulse(0, 8'h00, 2'h0);
		h.pulse(4, 8'h00, 2'h1);
		settle;
		`CHK(prot, 4'hF)
		wp_n = 1'b1;
		wr(8'h00);
		`CHK(sb, 8'h1C)
		wr(8'h43);
		`CHK(sb, 8'h10)
		`CHK(prot, 4'h0)
		h.pulse(0, 8'h00, 2'h0);
		h.pulse(3, 8'h00, 2'h2);
		settle;
		`CHK(prot, 4'h4)
		`CHK(sb[3:2], 2'h1)
		wr(8'h3C);
		`CHK(prot, 4'hF)
		`CHK(sb, 8'h1C)
		wr(8'h84);
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		settle;
		`CHK(sb, 8'h1C)
		$display("test lock done");
	endtask : t_lock
	task automatic t_engine;
		seq = 1'b1;
		busy = 1'b1;
		settle;
		`CHK(sb, 8'h5D)
		seq = 1'b0;
		busy = 1'b0;
		h.pulse(5, 8'h01, 2'h0);
		settle;
		`CHK(sb, 8'h3C)
		h.pulse(5, 8'h00, 2'h0);
		settle;
		`CHK(sb[5], 1'b0)
		h.pulse(6, 8'h01, 2'h0);
		settle;
		`CHK(sb[5], 1'b0)
		h.pulse(0, 8'h00, 2'h0);
		settle;
		`CHK(sb[1], 1'b1)
		h.pulse(1, 8'h00, 2'h0);
		settle;
		`CHK(sb[1], 1'b0)
		$display("test engine done");
	endtask : t_engine
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		#1000000;
		err_total++;
		tally_and_finish;
	end
	initial begin
		#1;
		t_reset;
		t_lock;
		t_engine;
		tally_and_finish;
	end
endmodule : flash_status_byte_one_tb
